//--- src/asp_serial_port.sv
// Asynchronous serial port, modes 1 to 3, with APB register access.
// Assumes timer1Ovf is a one-cycle pulse from a timer on core_clk and
// serialRxIn is an asynchronous pin.
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ns
`include "asp_params.svh"

// Overview of operation
// - Transmit and receive run fully independently
// - Mode 1: start, eight data, one stop
// - Mode 1 stop bit lands in ninth flag
// - Modes 2/3: start, eight LSB-first, ninth, stop
// - Transmit ninth bit sent as ninth data
// - Received ninth bit stored in ninth flag
// - Data buffer write starts a frame
// - Falling receive edge starts capture when enabled
// - Framing check only while its enable set
// - Missing stop bit sets framing error
// - Framing error sticks until software clears
// - With check on, receive done at stop
// - Separate baud source selects per direction
// - Internal rate: double, speed, reload formula
// - Generator: 8-bit reload, optional divide by PRESCALE (six by default)
// - Timer overflow gives tick, doubling doubles
module asp_serial_port
	import asp_pkg::*;
#(
	parameter int PRESCALE = `ASP_PRESCALE_DEF
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic timer1Ovf,
	input wire logic serialRxIn,
	output logic serialTxOut
);

	if (PRESCALE < 2) begin : g_badParam
		$error("asp_serial_port: PRESCALE must be at least 2");
	end

	asp_port_s s_q;
	asp_port_s s_d;
	logic genOvf;
	logic setupPhase;
	logic accessWr;
	logic ctrlWr;
	logic dataWr;
	logic asyncMode;
	logic txSrcTick;
	logic rxSrcTick;
	logic txTick16;
	logic rxTick16;
	logic rxFall;
	logic rxLevel;

	function automatic logic [7:0] rxByte(input logic [8:0] sh,
		input logic nine);
		rxByte = nine ? sh[7:0] : sh[8:1];
	endfunction

	////////////////////////////////////////////////////////////////////
	asp_baud_gen #(
		.CNT_W(8),
		.PRESCALE(PRESCALE)
	) u_baudGen (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.runBit(s_q.baudGenRunBit),
		.speedBit(s_q.baudSpeedBit),
		.reloadValue(s_q.baudReloadValue),
		.ovfTick(genOvf)
	);

	assign setupPhase = psel && !penable;
	assign accessWr = psel && penable && pwrite;
	assign ctrlWr = accessWr && (paddr == `ASP_OFS_CTRL);
	assign dataWr = accessWr && (paddr == `ASP_OFS_DATA);
	assign asyncMode = s_q.modeHi || s_q.modeLo;

	// Each direction picks its own source
	assign txSrcTick = s_q.txBaudSourceSel ? genOvf : timer1Ovf;
	assign rxSrcTick = s_q.rxBaudSourceSel ? genOvf : timer1Ovf;
	// Sixteen ticks per bit; without doubling every other overflow
	assign txTick16 = txSrcTick && (s_q.baudDoubleBit || s_q.txHalf);
	assign rxTick16 = rxSrcTick && (s_q.baudDoubleBit || s_q.rxHalf);
	assign rxLevel = s_q.rxSync[1];
	assign rxFall = s_q.rxPrev && !rxLevel;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [3:0] lastBit;
		logic [8:0] shNew;
		lastBit = 4'h0;
		shNew = 9'h000;
		s_d = s_q;
		s_d.rxSync = {s_q.rxSync[0], serialRxIn};
		s_d.rxPrev = rxLevel;
		s_d.slvErr = 1'b0;
		if (setupPhase) begin
			s_d.rdData = 32'h0000_0000;
			case (paddr)
			`ASP_OFS_CTRL: begin
				s_d.rdData[`ASP_CTRL_RXDONE_BIT] = s_q.rxCompleteFlag;
				s_d.rdData[`ASP_CTRL_TXDONE_BIT] = s_q.txCompleteFlag;
				s_d.rdData[`ASP_CTRL_RXNINTH_BIT] = s_q.rxNinthBit;
				s_d.rdData[`ASP_CTRL_TXNINTH_BIT] = s_q.txNinthBit;
				s_d.rdData[`ASP_CTRL_RXEN_BIT] = s_q.rxEnable;
				s_d.rdData[`ASP_CTRL_MODELO_BIT] = s_q.modeLo;
				s_d.rdData[`ASP_CTRL_MODEHI_BIT] = s_q.modeHi;
				s_d.rdData[`ASP_CTRL_FERR_BIT] = s_q.framingErrorFlag;
			end
			`ASP_OFS_DATA: s_d.rdData[7:0] = s_q.rxData;
			`ASP_OFS_PWR: begin
				s_d.rdData[`ASP_PWR_FCHK_BIT] = s_q.framingCheckEnable;
				s_d.rdData[`ASP_PWR_DOUBLE_BIT] = s_q.baudDoubleBit;
			end
			`ASP_OFS_BGEN: begin
				s_d.rdData[`ASP_BGEN_SPEED_BIT] = s_q.baudSpeedBit;
				s_d.rdData[`ASP_BGEN_RXSRC_BIT] = s_q.rxBaudSourceSel;
				s_d.rdData[`ASP_BGEN_TXSRC_BIT] = s_q.txBaudSourceSel;
				s_d.rdData[`ASP_BGEN_RUN_BIT] = s_q.baudGenRunBit;
			end
			`ASP_OFS_RELOAD: s_d.rdData[7:0] = s_q.baudReloadValue;
			default: s_d.slvErr = 1'b1;
			endcase
		end

		// Software writes first so hardware sets below win a tie
		if (ctrlWr) begin
			s_d.rxCompleteFlag = pwdata[`ASP_CTRL_RXDONE_BIT];
			s_d.txCompleteFlag = pwdata[`ASP_CTRL_TXDONE_BIT];
			s_d.rxNinthBit = pwdata[`ASP_CTRL_RXNINTH_BIT];
			s_d.txNinthBit = pwdata[`ASP_CTRL_TXNINTH_BIT];
			s_d.rxEnable = pwdata[`ASP_CTRL_RXEN_BIT];
			s_d.modeLo = pwdata[`ASP_CTRL_MODELO_BIT];
			s_d.modeHi = pwdata[`ASP_CTRL_MODEHI_BIT];
			s_d.framingErrorFlag = pwdata[`ASP_CTRL_FERR_BIT];
		end
		if (accessWr && paddr == `ASP_OFS_PWR) begin
			s_d.framingCheckEnable = pwdata[`ASP_PWR_FCHK_BIT];
			s_d.baudDoubleBit = pwdata[`ASP_PWR_DOUBLE_BIT];
		end
		if (accessWr && paddr == `ASP_OFS_BGEN) begin
			s_d.baudSpeedBit = pwdata[`ASP_BGEN_SPEED_BIT];
			s_d.rxBaudSourceSel = pwdata[`ASP_BGEN_RXSRC_BIT];
			s_d.txBaudSourceSel = pwdata[`ASP_BGEN_TXSRC_BIT];
			s_d.baudGenRunBit = pwdata[`ASP_BGEN_RUN_BIT];
		end
		if (accessWr && paddr == `ASP_OFS_RELOAD) begin
			s_d.baudReloadValue = pwdata[7:0];
		end

		if (txSrcTick) begin
			s_d.txHalf = !s_q.txHalf;
		end
		if (rxSrcTick) begin
			s_d.rxHalf = !s_q.rxHalf;
		end

		// Transmitter; a write while busy is dropped
		lastBit = s_q.modeHi ? 4'h8 : 4'h7;
		if (dataWr && s_q.txPhase == ASP_IDLE && asyncMode) begin
			s_d.txShift = {s_q.txNinthBit, pwdata[7:0]};
			s_d.txPhase = ASP_START;
			s_d.txTick = 4'h0;
			s_d.txBits = 4'h0;
		end else if (txTick16 && s_q.txPhase != ASP_IDLE) begin
			s_d.txTick = 4'(s_q.txTick + 4'h1);
			if (s_q.txTick == `ASP_TICK_LAST) begin
				case (s_q.txPhase)
				ASP_START: s_d.txPhase = ASP_DATA;
				ASP_DATA: begin
					s_d.txShift = {1'b1, s_q.txShift[8:1]};
					s_d.txBits = 4'(s_q.txBits + 4'h1);
					if (s_q.txBits == lastBit) begin
						s_d.txPhase = ASP_STOP;
					end
				end
				ASP_STOP: begin
					s_d.txPhase = ASP_IDLE;
					s_d.txCompleteFlag = 1'b1;
				end
				default: s_d.txPhase = ASP_IDLE;
				endcase
			end
		end
		case (s_d.txPhase)
		ASP_START: s_d.txLine = 1'b0;
		ASP_DATA: s_d.txLine = s_d.txShift[0];
		default: s_d.txLine = 1'b1;
		endcase

		// Receiver, sampling each bit at its middle tick
		shNew = {rxLevel, s_q.rxShift[8:1]};
		if (s_q.rxPhase == ASP_IDLE) begin
			if (rxFall && s_q.rxEnable && asyncMode) begin
				s_d.rxPhase = ASP_START;
				s_d.rxTick = 4'h0;
				s_d.rxBits = 4'h0;
			end
		end else if (rxTick16) begin
			s_d.rxTick = 4'(s_q.rxTick + 4'h1);
			case (s_q.rxPhase)
			ASP_START: begin
				// A glitch that is high again at mid-bit is no start
				if (s_q.rxTick == `ASP_START_MID) begin
					s_d.rxTick = 4'h0;
					s_d.rxPhase = rxLevel ? ASP_IDLE : ASP_DATA;
				end
			end
			ASP_DATA: begin
				if (s_q.rxTick == `ASP_TICK_LAST) begin
					s_d.rxShift = shNew;
					s_d.rxBits = 4'(s_q.rxBits + 4'h1);
					if (s_q.rxBits == lastBit) begin
						s_d.rxPhase = ASP_STOP;
						if (!s_q.framingCheckEnable) begin
							s_d.rxData = rxByte(shNew, s_q.modeHi);
							s_d.rxCompleteFlag = 1'b1;
							if (s_q.modeHi) begin
								s_d.rxNinthBit = shNew[8];
							end
						end
					end
				end
			end
			ASP_STOP: begin
				if (s_q.rxTick == `ASP_TICK_LAST) begin
					s_d.rxPhase = ASP_IDLE;
					if (!s_q.modeHi) begin
						s_d.rxNinthBit = rxLevel;
					end
					if (s_q.framingCheckEnable) begin
						s_d.rxData = rxByte(s_q.rxShift, s_q.modeHi);
						s_d.rxCompleteFlag = 1'b1;
						if (s_q.modeHi) begin
							s_d.rxNinthBit = s_q.rxShift[8];
						end
						if (!rxLevel) begin
							s_d.framingErrorFlag = 1'b1;
						end
					end
				end
			end
			default: s_d.rxPhase = ASP_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.baudReloadValue <= `ASP_RELOAD_RST;
			s_q.rxSync <= 2'b11;
			s_q.rxPrev <= 1'b1;
			s_q.txLine <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdData;
	assign pslverr = s_q.slvErr && psel && penable;
	assign pready = psel && penable;
	assign serialTxOut = s_q.txLine;

	////////////////////////////////////////////////////////////////////
	property p_idleHigh;
		@(posedge core_clk) disable iff (sys_rst)
		s_q.txPhase == ASP_IDLE |-> serialTxOut;
	endproperty
	a_idleHigh: assert property (p_idleHigh)
		else $error("transmit line low while idle");

	property p_writeStarts;
		@(posedge core_clk) disable iff (sys_rst)
		dataWr && s_q.txPhase == ASP_IDLE && asyncMode
			|=> s_q.txPhase == ASP_START && !serialTxOut;
	endproperty
	a_writeStarts: assert property (p_writeStarts)
		else $error("buffer write did not start a frame");

	property p_ninthLoaded;
		@(posedge core_clk) disable iff (sys_rst)
		dataWr && s_q.txPhase == ASP_IDLE && asyncMode
			|=> s_q.txShift[8] == $past(s_q.txNinthBit);
	endproperty
	a_ninthLoaded: assert property (p_ninthLoaded)
		else $error("ninth transmit bit not loaded");

	property p_doneAfterStop;
		@(posedge core_clk) disable iff (sys_rst)
		s_q.txPhase == ASP_STOP && txTick16 && s_q.txTick == `ASP_TICK_LAST
			|=> s_q.txCompleteFlag && s_q.txPhase == ASP_IDLE;
	endproperty
	a_doneAfterStop: assert property (p_doneAfterStop)
		else $error("transmit done flag missing after stop");

	property p_rxStart;
		@(posedge core_clk) disable iff (sys_rst)
		s_q.rxPhase == ASP_IDLE && rxFall && s_q.rxEnable && asyncMode
			|=> s_q.rxPhase == ASP_START;
	endproperty
	a_rxStart: assert property (p_rxStart)
		else $error("falling edge did not start reception");

	property p_stopToNinth;
		@(posedge core_clk) disable iff (sys_rst)
		s_q.rxPhase == ASP_STOP && rxTick16 && !s_q.modeHi
			&& s_q.rxTick == `ASP_TICK_LAST
			|=> s_q.rxNinthBit == $past(rxLevel);
	endproperty
	a_stopToNinth: assert property (p_stopToNinth)
		else $error("stop bit not kept in ninth flag");

	property p_errSticky;
		@(posedge core_clk) disable iff (sys_rst)
		s_q.framingErrorFlag && !ctrlWr |=> s_q.framingErrorFlag;
	endproperty
	a_errSticky: assert property (p_errSticky)
		else $error("framing error cleared without software");

	property p_errNeedsCheck;
		@(posedge core_clk) disable iff (sys_rst)
		!s_q.framingErrorFlag && !ctrlWr && !s_q.framingCheckEnable
			|=> !s_q.framingErrorFlag;
	endproperty
	a_errNeedsCheck: assert property (p_errNeedsCheck)
		else $error("framing error set while check disabled");

	property p_badStop;
		@(posedge core_clk) disable iff (sys_rst)
		s_q.rxPhase == ASP_STOP && rxTick16 && s_q.framingCheckEnable
			&& s_q.rxTick == `ASP_TICK_LAST && !rxLevel
			|=> s_q.framingErrorFlag && s_q.rxCompleteFlag;
	endproperty
	a_badStop: assert property (p_badStop)
		else $error("bad stop bit not flagged");

	property p_doneAtStop;
		@(posedge core_clk) disable iff (sys_rst)
		s_q.framingCheckEnable && s_q.rxPhase == ASP_DATA && !ctrlWr
			&& !s_q.rxCompleteFlag |=> !s_q.rxCompleteFlag;
	endproperty
	a_doneAtStop: assert property (p_doneAtStop)
		else $error("receive done raised before stop bit");

endmodule

//--- src/asp_params.svh
// Register offsets, field positions and reset values of the serial port.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH

////////////////////////////////////////////////////////////////////////
`define ASP_OFS_CTRL 12'h000
`define ASP_OFS_DATA 12'h004
`define ASP_OFS_PWR 12'h008
`define ASP_OFS_BGEN 12'h00C
`define ASP_OFS_RELOAD 12'h010

////////////////////////////////////////////////////////////////////////
`define ASP_CTRL_RXDONE_BIT 0
`define ASP_CTRL_TXDONE_BIT 1
`define ASP_CTRL_RXNINTH_BIT 2
`define ASP_CTRL_TXNINTH_BIT 3
`define ASP_CTRL_RXEN_BIT 4
`define ASP_CTRL_MODELO_BIT 6
`define ASP_CTRL_MODEHI_BIT 7
`define ASP_CTRL_FERR_BIT 8
`define ASP_PWR_FCHK_BIT 6
`define ASP_PWR_DOUBLE_BIT 7
`define ASP_BGEN_SPEED_BIT 1
`define ASP_BGEN_RXSRC_BIT 2
`define ASP_BGEN_TXSRC_BIT 3
`define ASP_BGEN_RUN_BIT 4

////////////////////////////////////////////////////////////////////////
`define ASP_RELOAD_RST 8'h00
`define ASP_PRESCALE_DEF 6
`define ASP_TICKS_PER_BIT 16
`define ASP_TICK_LAST 4'hF
`define ASP_START_MID 4'h7

`endif

//--- src/asp_pkg.sv
// Types shared by the serial port modules.
// Assumes asp_params.svh for all numeric constants.
package asp_pkg;

	typedef enum logic [1:0] {
		ASP_IDLE,
		ASP_START,
		ASP_DATA,
		ASP_STOP
	} asp_phase_e;

	typedef struct packed {
		logic modeHi;
		logic modeLo;
		logic rxEnable;
		logic txNinthBit;
		logic rxNinthBit;
		logic txCompleteFlag;
		logic rxCompleteFlag;
		logic framingErrorFlag;
		logic baudDoubleBit;
		logic framingCheckEnable;
		logic baudGenRunBit;
		logic txBaudSourceSel;
		logic rxBaudSourceSel;
		logic baudSpeedBit;
		logic [7:0] baudReloadValue;
		logic [7:0] rxData;
		logic [31:0] rdData;
		logic slvErr;
		logic [1:0] rxSync;
		logic rxPrev;
		logic txHalf;
		logic rxHalf;
		asp_phase_e txPhase;
		logic [3:0] txTick;
		logic [3:0] txBits;
		logic [8:0] txShift;
		logic txLine;
		asp_phase_e rxPhase;
		logic [3:0] rxTick;
		logic [3:0] rxBits;
		logic [8:0] rxShift;
	} asp_port_s;

endpackage

//--- src/asp_baud_gen.sv
// Internal auto-reload baud generator: one overflow pulse per wrap.
// Assumes run, speed and reload come from registers on core_clk.
`timescale 1ns/1ns
`include "asp_params.svh"
module asp_baud_gen
	import asp_pkg::*;
#(
	parameter int CNT_W = 8,
	parameter int PRESCALE = `ASP_PRESCALE_DEF
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic runBit,
	input wire logic speedBit,
	input wire logic [CNT_W-1:0] reloadValue,
	output logic ovfTick
);

	localparam int PW = $clog2(PRESCALE);

	if (CNT_W < 2 || PRESCALE < 2) begin : g_badParam
		$error("asp_baud_gen: CNT_W and PRESCALE must be at least 2");
	end

	typedef struct packed {
		logic [PW-1:0] pre;
		logic [CNT_W-1:0] cnt;
		logic ovf;
	} asp_bgen_s;

	asp_bgen_s s_q;
	asp_bgen_s s_d;
	logic step;

	////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		s_d.ovf = 1'b0;
		step = 1'b0;
		if (runBit) begin
			// Slow mode divides the peripheral clock first
			step = speedBit || (s_q.pre == PW'(PRESCALE - 1));
			if (speedBit || step) begin
				s_d.pre = '0;
			end else begin
				s_d.pre = PW'(s_q.pre + 1'b1);
			end
			if (step) begin
				if (s_q.cnt == '1) begin
					s_d.cnt = reloadValue;
					s_d.ovf = 1'b1;
				end else begin
					s_d.cnt = CNT_W'(s_q.cnt + 1'b1);
				end
			end
		end else begin
			s_d.pre = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign ovfTick = s_q.ovf;

	////////////////////////////////////////////////////////////////////
	property p_reloadAfterOvf;
		@(posedge core_clk) disable iff (sys_rst)
		ovfTick && $stable(reloadValue) |-> s_q.cnt == reloadValue;
	endproperty
	a_reloadAfterOvf: assert property (p_reloadAfterOvf)
		else $error("counter not reloaded at overflow");

	property p_haltWhenStopped;
		@(posedge core_clk) disable iff (sys_rst)
		!runBit ##1 !runBit |-> !ovfTick && $stable(s_q.cnt);
	endproperty
	a_haltWhenStopped: assert property (p_haltWhenStopped)
		else $error("generator moved while stopped");

endmodule

//--- verif/asp_remote_peer.sv
// Far-end serial partner: sends frames on the receive pin, captures the
// frames on the transmit pin. Assumes the bench sets bit lengths in cycles.
`timescale 1ns/1ns
module asp_remote_peer (
	core_clk,
	serialTxOut,
	serialRxIn
);
	input wire logic core_clk;
	input wire logic serialTxOut;
	output logic serialRxIn = 1'b1;

	int smpCycles = 64;
	int smpBits = 10;
	int k;
	logic [10:0] rxFrame;
	logic [10:0] gotFrames[$];

	////////////////////////////////////////////////////////////////////////
	// Line idles high between frames, as any async partner would
	task automatic send_frame(input logic [7:0] data, input logic ninth,
		input int nBits, input logic stopLvl, input int bitCycles);
		logic [10:0] f;
		f = (nBits == 10) ? {1'b1, stopLvl, data, 1'b0}
			: {stopLvl, ninth, data, 1'b0};
		for (int i = 0; i < nBits; i++) begin
			serialRxIn <= f[i];
			repeat (bitCycles) @(posedge core_clk);
		end
		serialRxIn <= 1'b1;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Mid-bit sampling; unsampled top bit stays high in 10-bit frames
	always begin
		@(negedge serialTxOut);
		rxFrame = 11'h7FF;
		repeat (smpCycles / 2) @(posedge core_clk);
		for (k = 0; k < smpBits; k++) begin
			rxFrame[k] = serialTxOut;
			if (k < smpBits - 1) begin
				repeat (smpCycles) @(posedge core_clk);
			end
		end
		gotFrames.push_back(rxFrame);
	end
endmodule

//--- verif/asp_serial_port_test.sv
// Self-checking bench for the serial port: APB master, reference flags,
// far-end peer. Assumes the design answers APB with its own pready.
`timescale 1ns/1ns
`include "asp_params.svh"
module asp_serial_port_test;
	localparam int PRESC = 2;
	localparam int T1DIV = 3;

	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic timer1Ovf = 1'b0;
	logic serialRxIn;
	logic serialTxOut;
	int failures = 0;
	int total_checks = 0;
	int rxBit;
	int txBit;
	int t1Cnt = 0;
	logic [31:0] mCtrl = 32'h0;
	logic [31:0] rd;
	logic err;

	always #4 core_clk = ~core_clk;

	// Stand-in timer 1 overflow pulse
	always @(posedge core_clk) begin
		t1Cnt <= (t1Cnt == T1DIV - 1) ? 0 : t1Cnt + 1;
		timer1Ovf <= (t1Cnt == T1DIV - 1);
	end

	asp_serial_port #(.PRESCALE(PRESC)) u_dut (.core_clk(core_clk),
		.sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer1Ovf(timer1Ovf), .serialRxIn(serialRxIn),
		.serialTxOut(serialTxOut));

	asp_remote_peer u_peer (.core_clk(core_clk),
		.serialTxOut(serialTxOut), .serialRxIn(serialRxIn));

	////////////////////////////////////////////////////////////////////////
	task report_and_stop;
		if (failures == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_frame(input logic [10:0] got, input logic [10:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t frame got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Holds the request until pready is seen; idle cycle after each transfer
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		penable <= 1'b0;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) begin
			@(posedge core_clk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Cycles per bit: 16 ticks, a tick per overflow only when doubled
	function automatic int bit_cycles(logic src, logic baud_speed_bit, logic dbl,
		logic [7:0] rl);
		int step;
		step = src ? (256 - rl) * (baud_speed_bit ? 1 : PRESC) : T1DIV;
		return 16 * (dbl ? 1 : 2) * step;
	endfunction

	task automatic set_baud(input logic rs, input logic ts, input logic baud_speed_bit,
		input logic dbl, input logic [7:0] rl);
		logic [31:0] b;
		logic [31:0] r;
		logic e;
		b = {27'b0, 1'b1, ts, rs, baud_speed_bit, 1'b0};
		apb(1'b1, `ASP_OFS_RELOAD, {24'b0, rl}, r, e);
		apb(1'b1, `ASP_OFS_BGEN, b, r, e);
		apb(1'b1, `ASP_OFS_PWR, {24'b0, dbl, 7'b0}, r, e);
		apb(1'b0, `ASP_OFS_BGEN, 32'h0, r, e);
		chk_reg(r, b);
		apb(1'b0, `ASP_OFS_RELOAD, 32'h0, r, e);
		chk_reg(r, {24'b0, rl});
		rxBit = bit_cycles(rs, baud_speed_bit, dbl, rl);
		txBit = bit_cycles(ts, baud_speed_bit, dbl, rl);
		// A fresh generator needs a full count before its first tick
		repeat (256 * PRESC) @(posedge core_clk);
	endtask

	// Receive only; flag is probed a quarter into the stop bit
	task automatic rx_case(input logic [1:0] md, input logic [7:0] data,
		input logic ninth, input logic stp, input logic fchk);
		int nb;
		logic [31:0] r;
		logic e;
		nb = (md == 2'd1) ? 10 : 11;
		mCtrl = {23'b0, mCtrl[8], md, 1'b0, 1'b1, 4'b0};
		apb(1'b1, `ASP_OFS_CTRL, mCtrl, r, e);
		apb(1'b1, `ASP_OFS_PWR, {24'b0, 1'b1, fchk, 6'b0}, r, e);
		fork
			u_peer.send_frame(data, ninth, nb, stp, rxBit);
			begin
				repeat ((nb - 1) * rxBit + rxBit / 4) @(posedge core_clk);
				apb(1'b0, `ASP_OFS_CTRL, 32'h0, r, e);
				chk_reg({31'b0, r[0]}, {31'b0, !fchk});
			end
		join
		repeat (rxBit) @(posedge core_clk);
		mCtrl[0] = 1'b1;
		mCtrl[2] = (nb == 10) ? stp : ninth;
		if (fchk && !stp) mCtrl[8] = 1'b1;
		apb(1'b0, `ASP_OFS_CTRL, 32'h0, r, e);
		chk_reg(r, mCtrl);
		apb(1'b0, `ASP_OFS_DATA, 32'h0, r, e);
		chk_reg(r, {24'b0, data});
	endtask

	// Send and receive at once, each at its own selected rate
	task automatic duplex_case(input logic [1:0] md, input logic [7:0] txd,
		input logic txn, input logic [7:0] rxd, input logic rxn);
		int nb;
		logic [31:0] r;
		logic e;
		logic [10:0] exp;
		nb = (md == 2'd1) ? 10 : 11;
		mCtrl = {23'b0, mCtrl[8], md, 1'b0, 1'b1, txn, 3'b0};
		apb(1'b1, `ASP_OFS_CTRL, mCtrl, r, e);
		u_peer.smpCycles = txBit;
		u_peer.smpBits = nb;
		apb(1'b1, `ASP_OFS_DATA, {24'b0, txd}, r, e);
		u_peer.send_frame(rxd, rxn, nb, 1'b1, rxBit);
		while (u_peer.gotFrames.size() == 0) begin
			@(posedge core_clk);
		end
		repeat (txBit) @(posedge core_clk);
		exp = (nb == 10) ? {2'b11, txd, 1'b0} : {1'b1, txn, txd, 1'b0};
		chk_frame(u_peer.gotFrames.pop_front(), exp);
		chk_reg({31'b0, serialTxOut}, 32'h1);
		mCtrl[1:0] = 2'b11;
		mCtrl[2] = (nb == 10) ? 1'b1 : rxn;
		apb(1'b0, `ASP_OFS_CTRL, 32'h0, r, e);
		chk_reg(r, mCtrl);
		apb(1'b0, `ASP_OFS_DATA, 32'h0, r, e);
		chk_reg(r, {24'b0, rxd});
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (40000) @(posedge core_clk);
		failures++;
		report_and_stop();
	end

	initial begin
		rd = $urandom(39552);
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		chk_reg({31'b0, serialTxOut}, 32'h1);
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 12'(4 * i), 32'h0, rd, err);
			chk_reg(rd, 32'h0);
		end
		// Unmapped word must be refused both ways
		apb(1'b1, 12'h014, $urandom, rd, err);
		chk_reg({31'b0, err}, 32'h1);
		apb(1'b0, 12'h014, 32'h0, rd, err);
		chk_reg({rd[30:0], err}, 32'h1);
		set_baud(1'b1, 1'b1, 1'b1, 1'b1, 8'hFC);
		for (int i = 1; i < 4; i++) begin
			rx_case(i[1:0], 8'($urandom), 1'($urandom), 1'b1, 1'b0);
		end
		rx_case(2'd1, 8'($urandom), 1'b1, 1'b0, 1'b0);
		rx_case(2'd3, 8'($urandom), 1'($urandom), 1'b0, 1'b1);
		rx_case(2'd2, 8'($urandom), 1'($urandom), 1'b1, 1'b1);
		mCtrl = 32'h0;
		apb(1'b1, `ASP_OFS_CTRL, mCtrl, rd, err);
		apb(1'b0, `ASP_OFS_CTRL, 32'h0, rd, err);
		chk_reg(rd, mCtrl);
		// Mode 0 is inert here: a buffer write must not start a frame
		apb(1'b1, `ASP_OFS_DATA, $urandom, rd, err);
		repeat (4) @(posedge core_clk);
		chk_reg({31'b0, serialTxOut}, 32'h1);
		for (int i = 1; i < 4; i++) begin
			duplex_case(i[1:0], 8'($urandom), 1'($urandom), 8'($urandom),
				1'($urandom));
		end
		set_baud(1'b0, 1'b1, 1'b0, 1'b1, 8'hFE);
		duplex_case(2'd3, 8'($urandom), 1'($urandom), 8'($urandom),
			1'($urandom));
		duplex_case(2'd1, 8'($urandom), 1'b0, 8'($urandom), 1'b0);
		set_baud(1'b1, 1'b0, 1'b1, 1'b0, 8'hFE);
		duplex_case(2'd2, 8'($urandom), 1'($urandom), 8'($urandom),
			1'($urandom));
		report_and_stop();
	end
endmodule
